// ===== sdm_config_mask.sv
// sdm_config_mask: configuration, led source selection, watchdogs and fault-pin masking.
// assumes detector and pin inputs are asynchronous; registers reached over AXI4-Lite.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module sdm_config_mask #(
  parameter int unsigned WDOG_SHORT_CYCLES = sdm_pkg::WDOG_SHORT_CYC,
  parameter int unsigned WDOG_MID_CYCLES = sdm_pkg::WDOG_MID_CYC,
  parameter int unsigned WDOG_LONG_CYCLES = sdm_pkg::WDOG_LONG_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire sdm_pkg::sdm_pins_t i_pins,
  output logic o_fault_n,
  output logic [7:0] o_status_led,
  output logic [7:0] o_fault_led,
  output logic [1:0] o_openwire_off_current_sel,
  output logic [1:0] o_short_supply_thr_sel,
  output logic o_turnon_good_thr,
  output logic [7:0] o_openwire_off_det_en,
  output logic [7:0] o_openwire_on_det_en,
  output logic [7:0] o_short_supply_det_en,
  output logic o_comm_error_irq,
  output logic o_supply_error_irq,
  output logic o_global_irq_flag,
  output logic o_supply_err_sdo_bit,
  output logic o_overload_sdo_bit
);
  import sdm_pkg::*;

  // synced pins, counters, registers, bus state

  typedef struct packed {
    sdm_pins_t sync1;
    sdm_pins_t sync2;
    logic link_prev;
    logic update_prev;
    logic [CNT_W-1:0] serial_cnt;
    logic [CNT_W-1:0] update_cnt;
    logic serial_wdog_timeout_flag;
    logic update_pin_timeout_flag;
    sdm_cfg_t cfg;
    sdm_mask_t mask;
    logic status_led_sw_ctrl;
    logic fault_led_sw_ctrl;
    logic [7:0] status_led_values;
    logic [7:0] fault_led_values;
    logic [7:0] owoff_en;
    logic [7:0] owon_en;
    logic [7:0] short_en;
    logic aw_held;
    logic [5:0] aw_idx;
    logic w_held;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic fault_n;
    logic [7:0] status_led;
    logic [7:0] fault_led;
  } sdm_state_t;

  sdm_state_t st;
  sdm_state_t next_st;

  localparam logic [CNT_W-1:0] LIM_SHORT = CNT_W'(WDOG_SHORT_CYCLES - 1);
  localparam logic [CNT_W-1:0] LIM_MID = CNT_W'(WDOG_MID_CYCLES - 1);
  localparam logic [CNT_W-1:0] LIM_LONG = CNT_W'(WDOG_LONG_CYCLES - 1);

  sdm_pins_t pin;
  logic chain;
  logic serial_en;
  logic update_en;
  logic [CNT_W-1:0] serial_lim;
  logic [CNT_W-1:0] update_lim;
  logic serial_to;
  logic update_to;
  logic [7:0] short_flag;
  logic [7:0] owon_flag;
  logic [7:0] owoff_flag;
  logic [7:0] curlim_flag;
  logic supply_err;
  logic comm_err;
  logic fault_any;
  logic global_flag;
  logic wr_fire;
  logic [7:0] wb;
  logic clr_serial;
  logic clr_update;
  logic [31:0] rd_word;
  logic rd_ok;

  // single next-state process
  always_comb begin
    pin = st.sync2;
    chain = pin.chain_mode;
    // watchdog selection
    // chain mode: straps enable, longest period
    if (chain) begin
      serial_en = pin.addr0_wdog_strap;
      update_en = pin.addr1_sync_wdog_strap;
      serial_lim = LIM_LONG;
      update_lim = LIM_LONG;
    end else begin
      serial_en = (st.cfg.wdog_timeout_sel != 2'b00);
      update_en = st.cfg.sync_wdog_en;
      unique case (st.cfg.wdog_timeout_sel)
        2'b00: begin
          serial_lim = LIM_MID;
          update_lim = LIM_MID;
        end
        2'b01: begin
          serial_lim = LIM_SHORT;
          update_lim = LIM_SHORT;
        end
        2'b10: begin
          serial_lim = LIM_MID;
          update_lim = LIM_MID;
        end
        2'b11: begin
          serial_lim = LIM_LONG;
          update_lim = LIM_LONG;
        end
      endcase
    end

    // fires when the count reaches its limit
    serial_to = serial_en && (st.serial_cnt == serial_lim);
    update_to = update_en && (st.update_cnt == update_lim);

    // detection gating, chain mode switches off the optional classes
    short_flag = chain ? 8'h00 : (pin.short_supply & st.short_en);
    owon_flag = chain ? 8'h00 : (pin.openwire_on & st.owon_en);
    owoff_flag = chain ? 8'h00 : (pin.openwire_off & st.owoff_en);
    curlim_flag = chain ? 8'h00 : pin.current_limit;


    // interrupt classes
    supply_err = pin.supply_uvlo | (~st.mask.supply_ok_mask & (pin.supply_low | pin.supply_warning));
    comm_err = st.serial_wdog_timeout_flag | st.update_pin_timeout_flag;
    global_flag = comm_err | supply_err | (|short_flag) | (|owon_flag) | (|owoff_flag)
      | (|curlim_flag) | (|pin.overload);

    // chain mode: only overload reaches the pin
    fault_any = 1'b0;
    if (!chain) begin
      fault_any = (comm_err & ~st.mask.comm_err_mask)
        | (supply_err & ~st.mask.supply_err_mask)
        | ((|short_flag) & ~st.mask.short_supply_mask)
        | ((|owon_flag) & ~st.mask.openwire_on_mask)
        | ((|owoff_flag) & ~st.mask.openwire_off_mask)
        | ((|curlim_flag) & ~st.mask.current_limit_mask);
    end
    fault_any = fault_any | ((|pin.overload) & ~st.mask.overload_mask);

    // bus write decode
    wr_fire = st.aw_held && st.w_held && !st.bvalid;
    wb = st.w_byte;
    clr_serial = wr_fire && st.w_lane0 && (st.aw_idx == IDX_EVENT_STATUS) && wb[EV_SERIAL_WDOG];
    clr_update = wr_fire && st.w_lane0 && (st.aw_idx == IDX_EVENT_STATUS) && wb[EV_UPDATE_WDOG];

    // read mux
    // unmapped index: zero data, SLVERR
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (i_araddr[7:2])
      IDX_OWOFF_EN: rd_word[7:0] = st.owoff_en;
      IDX_OWON_EN: rd_word[7:0] = st.owon_en;
      IDX_SHORT_EN: rd_word[7:0] = st.short_en;
      IDX_LED_CTRL: rd_word[1:0] = {st.status_led_sw_ctrl, st.fault_led_sw_ctrl};
      IDX_WDOG_DETECT_CFG: rd_word[7:0] = st.cfg;
      IDX_FAULT_MASK: rd_word[7:0] = st.mask;
      IDX_STATUS_LED_VAL: rd_word[7:0] = st.status_led_values;
      IDX_FAULT_LED_VAL: rd_word[7:0] = st.fault_led_values;
      IDX_EVENT_STATUS: begin
        rd_word[EV_SERIAL_WDOG] = st.serial_wdog_timeout_flag;
        rd_word[EV_UPDATE_WDOG] = st.update_pin_timeout_flag;
        rd_word[EV_COMM_IRQ] = o_comm_error_irq;
        rd_word[EV_SUPPLY_IRQ] = o_supply_error_irq;
        rd_word[EV_GLOBAL] = global_flag;
        rd_word[EV_FAULT] = ~st.fault_n;
      end
      IDX_CHAN_FLAGS: rd_word = {short_flag, owoff_flag, owon_flag, curlim_flag};
      IDX_OVERLOAD_FLAGS: rd_word[7:0] = pin.overload;
      default: rd_ok = 1'b0;
    endcase


    // hold by default
    next_st = st;
    next_st.sync1 = i_pins;
    next_st.sync2 = st.sync1;
    next_st.link_prev = pin.link_clk;
    next_st.update_prev = pin.update_pin;

    // serial watchdog restarts on every link clock edge and again from zero at its limit
    if (!serial_en || (pin.link_clk != st.link_prev) || serial_to) begin
      next_st.serial_cnt = '0;
    end else begin
      next_st.serial_cnt = st.serial_cnt + CNT_W'(1);
    end
    if (!update_en || (pin.update_pin != st.update_prev) || update_to) begin
      next_st.update_cnt = '0;
    end else begin
      next_st.update_cnt = st.update_cnt + CNT_W'(1);
    end
    // set wins over a same-cycle clear
    if (serial_to) begin
      next_st.serial_wdog_timeout_flag = 1'b1;
    end else if (clr_serial) begin
      next_st.serial_wdog_timeout_flag = 1'b0;
    end
    if (update_to) begin
      next_st.update_pin_timeout_flag = 1'b1;
    end else if (clr_update) begin
      next_st.update_pin_timeout_flag = 1'b0;
    end

    // write address and data are taken in either order
    if (i_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx = i_awaddr[7:2];
    end
    if (i_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_byte = i_wdata[7:0];
      next_st.w_lane0 = i_wstrb[0];
    end
    // response once both halves are held
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      // register bits sit in lane 0
      if (st.w_lane0) begin
        unique case (st.aw_idx)
          IDX_OWOFF_EN: next_st.owoff_en = wb;
          IDX_OWON_EN: next_st.owon_en = wb;
          IDX_SHORT_EN: next_st.short_en = wb;
          IDX_LED_CTRL: {next_st.status_led_sw_ctrl, next_st.fault_led_sw_ctrl} = wb[1:0];
          IDX_WDOG_DETECT_CFG: next_st.cfg = wb;
          IDX_FAULT_MASK: next_st.mask = wb;
          IDX_STATUS_LED_VAL: next_st.status_led_values = wb;
          IDX_FAULT_LED_VAL: next_st.fault_led_values = wb;
          IDX_EVENT_STATUS, IDX_CHAN_FLAGS, IDX_OVERLOAD_FLAGS: begin
          end
          default: next_st.bresp = RESP_SLVERR;
        endcase
      end else if (st.aw_idx > IDX_OVERLOAD_FLAGS || st.aw_idx < IDX_OWOFF_EN) begin
        next_st.bresp = RESP_SLVERR;
      end
    end

    // response leaves on its handshake
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end


    // read data captured at address handshake
    if (i_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end

    // led sources
    if (!chain && st.status_led_sw_ctrl) begin
      next_st.status_led = st.status_led_values;
    end else begin
      next_st.status_led = pin.channel_on;
    end
    if (chain) begin
      next_st.fault_led = pin.overload;
    end else if (st.fault_led_sw_ctrl) begin
      next_st.fault_led = st.fault_led_values;
    end else begin
      next_st.fault_led = pin.overload | curlim_flag | owon_flag | owoff_flag | short_flag;
    end
    next_st.fault_n = ~fault_any;
  end

  // reset loads constants only
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
      st.cfg <= RST_WDOG_DETECT_CFG;
      st.mask <= RST_FAULT_MASK;
      {st.status_led_sw_ctrl, st.fault_led_sw_ctrl} <= RST_LED_CTRL[1:0];
      st.status_led_values <= RST_ZERO;
      st.fault_led_values <= RST_ZERO;
      st.fault_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ready outputs decode held state
  assign o_awready = !st.aw_held;
  assign o_wready = !st.w_held;
  assign o_bvalid = st.bvalid;
  assign o_bresp = st.bresp;
  assign o_arready = !st.rvalid;
  assign o_rvalid = st.rvalid;
  assign o_rdata = st.rdata;
  assign o_rresp = st.rresp;
  assign o_fault_n = st.fault_n;
  assign o_status_led = st.status_led;
  assign o_fault_led = st.fault_led;

  // analog selections go to the detectors
  assign o_openwire_off_current_sel = st.cfg.openwire_off_current_sel;
  assign o_short_supply_thr_sel = st.cfg.short_supply_thr_sel;
  assign o_turnon_good_thr = st.cfg.turnon_thr_sel | chain;
  assign o_openwire_off_det_en = chain ? 8'h00 : st.owoff_en;
  assign o_openwire_on_det_en = chain ? 8'h00 : st.owon_en;
  assign o_short_supply_det_en = chain ? 8'h00 : st.short_en;

  // in chain mode the comm bit only exists with the check byte enabled
  assign o_comm_error_irq = comm_err & (!chain | pin.check_byte_enable_pin);
  assign o_supply_error_irq = supply_err;
  assign o_global_irq_flag = global_flag;
  assign o_supply_err_sdo_bit = chain ? (pin.check_byte_enable_pin & pin.supply_uvlo) : supply_err;
  assign o_overload_sdo_bit = |pin.overload;
endmodule

// ===== sdm_pkg.sv
// sdm_pkg: constants and carriers for the switch diagnostic config/mask block.
// assumes a 40 MHz core clock and 32-bit AXI4-Lite register access.
package sdm_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned WDOG_T_SHORT_MS = 200;
  localparam int unsigned WDOG_T_MID_MS = 600;
  localparam int unsigned WDOG_T_LONG_MS = 1200;
  localparam int unsigned WDOG_SHORT_CYC = CLK_HZ / 1000 * WDOG_T_SHORT_MS;
  localparam int unsigned WDOG_MID_CYC = CLK_HZ / 1000 * WDOG_T_MID_MS;
  localparam int unsigned WDOG_LONG_CYC = CLK_HZ / 1000 * WDOG_T_LONG_MS;
  localparam int CNT_W = 26;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_OWOFF_EN = 6'h0A;
  localparam logic [5:0] IDX_OWON_EN = 6'h0B;
  localparam logic [5:0] IDX_SHORT_EN = 6'h0C;
  localparam logic [5:0] IDX_LED_CTRL = 6'h0D;
  localparam logic [5:0] IDX_WDOG_DETECT_CFG = 6'h0E;
  localparam logic [5:0] IDX_FAULT_MASK = 6'h0F;
  localparam logic [5:0] IDX_STATUS_LED_VAL = 6'h10;
  localparam logic [5:0] IDX_FAULT_LED_VAL = 6'h11;
  localparam logic [5:0] IDX_EVENT_STATUS = 6'h12;
  localparam logic [5:0] IDX_CHAN_FLAGS = 6'h13;
  localparam logic [5:0] IDX_OVERLOAD_FLAGS = 6'h14;

  localparam logic [7:0] RST_WDOG_DETECT_CFG = 8'h00;
  localparam logic [7:0] RST_FAULT_MASK = 8'hBE;
  localparam logic [7:0] RST_LED_CTRL = 8'h03;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // event status bit positions
  localparam int EV_SERIAL_WDOG = 0;
  localparam int EV_UPDATE_WDOG = 1;
  localparam int EV_COMM_IRQ = 2;
  localparam int EV_SUPPLY_IRQ = 3;
  localparam int EV_GLOBAL = 4;
  localparam int EV_FAULT = 5;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // analog setting tables, index = two-bit select code
  localparam int unsigned OWOFF_CURRENT_UA [4] = '{20, 100, 300, 600};
  localparam int unsigned SHORT_THR_MV [4] = '{9000, 10000, 12000, 14000};

  typedef struct packed {
    logic [1:0] wdog_timeout_sel;
    logic [1:0] openwire_off_current_sel;
    logic [1:0] short_supply_thr_sel;
    logic sync_wdog_en;
    logic turnon_thr_sel;
  } sdm_cfg_t;

  typedef struct packed {
    logic comm_err_mask;
    logic supply_err_mask;
    logic supply_ok_mask;
    logic short_supply_mask;
    logic openwire_on_mask;
    logic openwire_off_mask;
    logic current_limit_mask;
    logic overload_mask;
  } sdm_mask_t;

  typedef struct packed {
    logic link_clk;
    logic update_pin;
    logic chain_mode;
    logic addr0_wdog_strap;
    logic addr1_sync_wdog_strap;
    logic check_byte_enable_pin;
    logic supply_uvlo;
    logic supply_low;
    logic supply_warning;
    logic [7:0] overload;
    logic [7:0] current_limit;
    logic [7:0] openwire_on;
    logic [7:0] openwire_off;
    logic [7:0] short_supply;
    logic [7:0] channel_on;
  } sdm_pins_t;
endpackage

// ===== sdm_config_mask_monitor.sv
// sdm_config_mask_monitor: port assertions for sdm_config_mask.
// assumes pins pass two sync flops before use.
`timescale 1ns/10ps
module sdm_config_mask_monitor (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire sdm_pkg::sdm_pins_t i_pins,
  input wire logic o_fault_n,
  input wire logic [7:0] o_status_led,
  input wire logic [7:0] o_fault_led,
  input wire logic o_turnon_good_thr,
  input wire logic [7:0] o_openwire_off_det_en,
  input wire logic [7:0] o_openwire_on_det_en,
  input wire logic [7:0] o_short_supply_det_en
);
  import sdm_pkg::*;
  logic [2:0] age;
  // edges since reset release, hides stale sync history
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  property p_b_hold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response left early");
  property p_r_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data left early");
  property p_r_lat; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_ch_det;
    age > 3'h3 && $past(i_pins.chain_mode, 2) |->
      (o_openwire_off_det_en | o_openwire_on_det_en | o_short_supply_det_en) == 8'h00;
  endproperty
  a_ch_det: assert property (p_ch_det) else $error("detection on in chain mode");
  property p_ch_thr; age > 3'h3 && $past(i_pins.chain_mode, 2) |-> o_turnon_good_thr; endproperty
  a_ch_thr: assert property (p_ch_thr) else $error("turn-on threshold low in chain mode");
  property p_ch_sled;
    age > 3'h3 && $past(i_pins.chain_mode, 3) |-> o_status_led == $past(i_pins.channel_on, 3);
  endproperty
  a_ch_sled: assert property (p_ch_sled) else $error("status leds not internal");
  property p_ch_fled;
    age > 3'h3 && $past(i_pins.chain_mode, 3) |-> o_fault_led == $past(i_pins.overload, 3);
  endproperty
  a_ch_fled: assert property (p_ch_fled) else $error("fault leds not overload only");
  property p_ch_fault;
    age > 3'h3 && $past(i_pins.chain_mode, 3) && $past(i_pins.overload, 3) == 8'h00 |-> o_fault_n;
  endproperty
  a_ch_fault: assert property (p_ch_fault) else $error("fault pin low in chain mode");
  c_fault: cover property (!o_fault_n);
  c_chain: cover property (age > 3'h3 && $past(i_pins.chain_mode, 3));
  c_read: cover property (o_rvalid && i_rready);
endmodule
bind sdm_config_mask sdm_config_mask_monitor u_sdm_config_mask_monitor (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .i_pins(i_pins), .o_fault_n(o_fault_n),
  .o_status_led(o_status_led), .o_fault_led(o_fault_led), .o_turnon_good_thr(o_turnon_good_thr),
  .o_openwire_off_det_en(o_openwire_off_det_en), .o_openwire_on_det_en(o_openwire_on_det_en),
  .o_short_supply_det_en(o_short_supply_det_en));

// ===== sdm_host.sv
// sdm_host: AXI4-Lite master model for the register port.
// assumes one clock; each wait is capped and reported through ok.
`timescale 1ns/10ps
module sdm_host (
  input wire logic i_core_clk,
  input wire logic i_awready,
  input wire logic i_wready,
  input wire logic [1:0] i_bresp,
  input wire logic i_bvalid,
  input wire logic i_arready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp,
  input wire logic i_rvalid,
  output logic [7:0] o_awaddr,
  output logic o_awvalid,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wvalid,
  output logic o_bready,
  output logic [7:0] o_araddr,
  output logic o_arvalid,
  output logic o_rready
);
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready, o_araddr, o_arvalid, o_rready} = '0;
  end
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] resp, output logic ok);
    logic a, w, b;
    int n;
    n = 0;
    @(posedge i_core_clk);
    o_awaddr <= {idx, 2'b00};
    o_wdata <= d;
    o_wstrb <= 4'hF;
    {o_awvalid, o_wvalid, o_bready} <= 3'h7;
    // sample between edges, act just after the edge
    do begin
      @(negedge i_core_clk);
      {a, w, b, resp} = {o_awvalid & i_awready, o_wvalid & i_wready, i_bvalid, i_bresp};
      @(posedge i_core_clk);
      if (a) o_awvalid <= 1'b0;
      if (w) o_wvalid <= 1'b0;
      n++;
    end while (!b && n < 40);
    o_bready <= 1'b0;
    ok = b;
  endtask
  task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp, output logic ok);
    logic a, r;
    int n;
    n = 0;
    @(posedge i_core_clk);
    o_araddr <= {idx, 2'b00};
    {o_arvalid, o_rready} <= 2'h3;
    do begin
      @(negedge i_core_clk);
      {a, r, d, resp} = {o_arvalid & i_arready, i_rvalid, i_rdata, i_rresp};
      @(posedge i_core_clk);
      if (a) o_arvalid <= 1'b0;
      n++;
    end while (!r && n < 40);
    o_rready <= 1'b0;
    ok = r;
  endtask
endmodule

// ===== test_switch_diag_config_mask.sv
// test_switch_diag_config_mask: self-checking bench for sdm_config_mask.
// assumes sdm_host on the bus; the bench drives all pins.
`timescale 1ns/10ps
module test_switch_diag_config_mask;
  import sdm_pkg::*;
  localparam int WS = 20;
  localparam int WM = 60;
  localparam int WL = 120;
  logic core_clk, reset_n, run, ok, awv, awr, wv, wrd, bv, br, arv, arr, rvl, rr;
  logic fault_n, tgood, cirq, sirq, gflag, sdo_s, sdo_o;
  logic [7:0] awaddr, araddr, sled, fled, offen, onen, shen, d, dof, don, dsh;
  logic [31:0] wdata, rdata, rv, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, ocs, sthr, resp;
  sdm_pins_t pins;
  int err_count, num_checks;
  sdm_config_mask #(.WDOG_SHORT_CYCLES(WS), .WDOG_MID_CYCLES(WM), .WDOG_LONG_CYCLES(WL)) u_sdm_config_mask (
    .i_core_clk(core_clk), .i_reset_n(reset_n), .i_awaddr(awaddr), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wv), .o_wready(wrd), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(br), .i_araddr(araddr), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvl), .i_rready(rr), .i_pins(pins), .o_fault_n(fault_n), .o_status_led(sled),
    .o_fault_led(fled), .o_openwire_off_current_sel(ocs), .o_short_supply_thr_sel(sthr),
    .o_turnon_good_thr(tgood), .o_openwire_off_det_en(dof), .o_openwire_on_det_en(don),
    .o_short_supply_det_en(dsh), .o_comm_error_irq(cirq), .o_supply_error_irq(sirq),
    .o_global_irq_flag(gflag), .o_supply_err_sdo_bit(sdo_s), .o_overload_sdo_bit(sdo_o));
  sdm_host u_sdm_host (.i_core_clk(core_clk), .i_awready(awr), .i_wready(wrd), .i_bresp(bresp),
    .i_bvalid(bv), .i_arready(arr), .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvl), .o_awaddr(awaddr),
    .o_awvalid(awv), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wv), .o_bready(br), .o_araddr(araddr),
    .o_arvalid(arv), .o_rready(rr));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // 200 ns link and update clocks, off the core phase
  initial begin
    #3;
    forever #100 if (run) {pins.link_clk, pins.update_pin} = ~{pins.link_clk, pins.update_pin};
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    err_count++;
    conclude();
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic int lim(input logic [1:0] c);
    return (c == 2'h1) ? WS : (c == 2'h3) ? WL : WM;
  endfunction
  function automatic logic [7:0] fexp(input sdm_pins_t p, input logic [7:0] f, n, s);
    return p.overload | p.current_limit | (p.openwire_off & f) | (p.openwire_on & n) | (p.short_supply & s);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] v);
    u_sdm_host.wr(i, {24'h00_0000, v}, resp, ok);
    if (!ok) begin
      err_count++;
      conclude();
    end
  endtask
  task automatic rd(input logic [5:0] i);
    u_sdm_host.rd(i, rv, resp, ok);
    if (!ok) begin
      err_count++;
      conclude();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic setc(input int k, input logic [7:0] v);
    case (k)
      0: pins.overload <= v;
      1: pins.current_limit <= v;
      2: pins.openwire_off <= v;
      3: pins.openwire_on <= v;
      default: pins.short_supply <= v;
    endcase
  endtask
  // toggle links, clear latched flags, then stop the links
  task automatic arm;
    run = 1'b1;
    cyc(12);
    wr(IDX_EVENT_STATUS, 8'h03);
    cyc(12);
    run = 1'b0;
  endtask
  initial begin
    reset_n = 1'b0;
    run = 1'b0;
    pins = '0;
    seed = 32'h0000_8aee;
    err_count = 0;
    num_checks = 0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(IDX_WDOG_DETECT_CFG);
    chk("cfg_reset", rv, {24'h00_0000, RST_WDOG_DETECT_CFG});
    rd(IDX_FAULT_MASK);
    chk("mask_reset", rv, {24'h00_0000, RST_FAULT_MASK});
    rd(6'h3F);
    chk("unmapped", {rv, resp}, {32'h0000_0000, RESP_SLVERR});
    wr(IDX_CHAN_FLAGS, 8'hFF);
    rd(IDX_CHAN_FLAGS);
    chk("read_only", {rv, resp}, {32'h0000_0000, RESP_OKAY});
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d = (i < 4) ? {2'b00, i[1:0], ~i[1:0], 1'b0, i[0]} : {2'b00, seed[5:2], 1'b0, seed[0]};
      wr(IDX_WDOG_DETECT_CFG, d);
      cyc(2);
      chk("owoff_cs", ocs, d[5:4]);
      chk("short_thr", sthr, d[3:2]);
      chk("turnon", tgood, d[0]);
    end
    $display("test settings done");
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      {shen, onen, offen} = seed[23:0];
      wr(IDX_OWOFF_EN, offen);
      wr(IDX_OWON_EN, onen);
      wr(IDX_SHORT_EN, shen);
      wr(IDX_LED_CTRL, 8'h03);
      seed = xs(seed);
      wr(IDX_STATUS_LED_VAL, seed[7:0]);
      wr(IDX_FAULT_LED_VAL, seed[15:8]);
      {pins.channel_on, pins.overload} <= seed[31:16];
      {pins.current_limit, pins.openwire_on, pins.openwire_off, pins.short_supply} <= xs(seed);
      cyc(4);
      chk("sled_sw", sled, seed[7:0]);
      chk("fled_sw", fled, seed[15:8]);
      wr(IDX_LED_CTRL, 8'h00);
      cyc(2);
      chk("sled_int", sled, pins.channel_on);
      chk("fled_int", fled, fexp(pins, offen, onen, shen));
      pins.chain_mode <= 1'b1;
      wr(IDX_LED_CTRL, 8'h03);
      cyc(4);
      chk("chain_leds", {sled, fled}, {pins.channel_on, pins.overload});
      chk("chain_det", {dof, don, dsh, tgood}, 25'h000_0001);
      pins.chain_mode <= 1'b0;
    end
    $display("test leds done");
    {pins.overload, pins.current_limit, pins.openwire_on, pins.openwire_off, pins.short_supply} <= '0;
    wr(IDX_OWOFF_EN, 8'hFF);
    wr(IDX_OWON_EN, 8'hFF);
    wr(IDX_SHORT_EN, 8'hFF);
    for (int k = 0; k < 5; k++) begin
      seed = xs(seed);
      wr(IDX_FAULT_MASK, 8'h00);
      setc(k, 8'h01 << seed[2:0]);
      cyc(4);
      chk("fault_on", fault_n, 1'b0);
      wr(IDX_FAULT_MASK, 8'h01 << k);
      cyc(2);
      chk("fault_masked", fault_n, 1'b1);
      rd(k == 0 ? IDX_OVERLOAD_FLAGS : IDX_CHAN_FLAGS);
      chk("flag_kept", rv != 0, 1'b1);
      chk("ovl_sdo", sdo_o, k == 0);
      setc(k, 8'h00);
    end
    wr(IDX_FAULT_MASK, 8'h00);
    pins.supply_low <= 1'b1;
    cyc(4);
    chk("supply_fault", {fault_n, sirq}, 2'b01);
    wr(IDX_FAULT_MASK, 8'h20);
    cyc(2);
    chk("okmask", {fault_n, sirq}, 2'b10);
    pins.supply_low <= 1'b0;
    pins.supply_uvlo <= 1'b1;
    wr(IDX_FAULT_MASK, 8'h40);
    cyc(4);
    chk("supmask", {fault_n, sirq, gflag}, 3'h7);
    pins.supply_uvlo <= 1'b0;
    $display("test masks done");
    for (int c = 0; c < 4; c++) begin
      wr(IDX_WDOG_DETECT_CFG, {c[1:0], 6'h02});
      arm();
      cyc(lim(c[1:0]) - 6);
      chk("wdog_early", cirq, 1'b0);
      cyc(18);
      rd(IDX_EVENT_STATUS);
      chk("wdog_flags", rv[1:0], {1'b1, c != 0});
    end
    wr(IDX_WDOG_DETECT_CFG, 8'h00);
    arm();
    cyc(90);
    rd(IDX_EVENT_STATUS);
    chk("sync_off", rv[1:0], 2'b00);
    wr(IDX_WDOG_DETECT_CFG, 8'h40);
    cyc(40);
    wr(IDX_FAULT_MASK, 8'h00);
    cyc(2);
    chk("wdog_fault", fault_n, 1'b0);
    wr(IDX_FAULT_MASK, 8'h80);
    cyc(2);
    chk("wdog_masked", {fault_n, cirq, gflag}, 3'h7);
    $display("test watchdogs done");
    pins.chain_mode <= 1'b1;
    pins.addr0_wdog_strap <= 1'b1;
    wr(IDX_FAULT_MASK, 8'h00);
    arm();
    cyc(100);
    rd(IDX_EVENT_STATUS);
    chk("chain_wd_early", rv[0], 1'b0);
    cyc(40);
    rd(IDX_EVENT_STATUS);
    chk("chain_wd", rv[1:0], 2'b01);
    pins.supply_uvlo <= 1'b1;
    pins.check_byte_enable_pin <= 1'b1;
    cyc(4);
    chk("chain_fault", {fault_n, sdo_s, cirq}, 3'h7);
    $display("test chain done");
    conclude();
  end
endmodule
